// >>> hw/i2cs_cond.sv
`timescale 1ns/100ps
module i2cs_cond (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic scl_s,
	input wire logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);
	logic scl_d_reg;
	logic sda_d_reg;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
endmodule

// >>> hw/i2cs_consts.svh
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets, byte addresses on the APB.
// ----------------------------------------------------------------
`define I2CS_OFF_CTRL 8'h00
`define I2CS_OFF_STAT 8'h04
`define I2CS_OFF_DATA 8'h08
`define I2CS_OFF_ADDR 8'h0C
// ----------------------------------------------------------------
// Field positions and values.
// ----------------------------------------------------------------
`define I2CS_MODE_HI 7
`define I2CS_MODE_LO 5
`define I2CS_EN_BIT 1
`define I2CS_MODE_I2C 3'h6
`define I2CS_MODE_RST 3'h7
`define I2CS_CF 7
`define I2CS_MATCH 6
`define I2CS_BUSY 5
`define I2CS_HTX 4
`define I2CS_TRANSMIT_ACK_CONTROL 3
`define I2CS_RW 2
`define I2CS_WAKE 1
`define I2CS_RECEIVE_ACK_FLAG 0
`define I2CS_BITS 4'h8
`define I2CS_LAST_BIT 4'h7
`endif

// >>> hw/i2cs_pkg.sv
package i2cs_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_HOLD = 7'h08,
		ST_DATA = 7'h10,
		ST_DACK = 7'h20,
		ST_WSTOP = 7'h40
	} i2cs_state_e;
endpackage

// >>> hw/i2cs_sync.sv
`timescale 1ns/100ps
module i2cs_sync #(
	parameter int WIDTH = 2
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	if (WIDTH < 1) begin : g_chk
		$error("i2cs_sync needs WIDTH of at least one");
	end

	// Idle bus lines are high, so both stages reset high.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta_reg <= '1;
			sync_out <= '1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// >>> hw/i2cs_top.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "i2cs_consts.svh"
// Notes on behaviour
// - Own 7-bit address sits in address register bits 7 to 1.
// - Address register bit 0 is plain storage with no function.
// - Data falling while clock is high is a start; busy goes high.
// - First seven bits after start form the address, MSB first.
// - Address equal to own address sets match flag and interrupt.
// - Eighth bit after start is stored as the read/write flag.
// - On match the data line is pulled low on the ninth clock.
// - Clock is held low until software writes data when sending or reads it when receiving.
// - Data bytes are eight bits, MSB first, both directions.
// - Receiving, the transmit-ack bit drives the ninth clock.
// - Sending, master ack is stored; no ack releases and waits stop.
// - Received byte lands in data register; sent byte comes from it.
// - A received byte gets a low acknowledge only while the transmit-ack bit is clear.
// - Done flag low while a data byte moves, high plus interrupt at end.
// - A stop clears the busy flag.
// - Enable rising in two-wire mode resets flags, not control bits.
// - With wake enable set, an address match raises wake request.
module i2cs_top #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq_req,
	output logic wake_req
);
	if (ADDR_W < 4) begin : g_chk
		$error("i2cs_top needs ADDR_W of at least four");
	end

	// ----------------------------------------------------------------
	// Pin synchronisation and bus conditions
	// ----------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	i2cs_sync #(.WIDTH(2)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.async_in({scl_i, sda_i}),
		.sync_out({scl_s, sda_s})
	);

	i2cs_cond u_cond (
		.core_clk(core_clk),
		.nrst(nrst),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [2:0] mode_reg;
	logic en_reg;
	logic en_d_reg;
	logic cf_reg;
	logic match_reg;
	logic busy_reg;
	logic htx_reg;
	logic transmit_ack_control_reg;
	logic rw_reg;
	logic wake_en_reg;
	logic receive_ack_flag_reg;
	logic [7:0] data_reg;
	logic [7:0] addr_reg;
	logic [7:0] shift_reg;
	logic [3:0] cnt_reg;
	logic [31:0] prdata_reg;
	logic sda_oe_reg;
	logic scl_oe_reg;
	logic irq_reg;
	logic wake_reg;
	i2cs_pkg::i2cs_state_e state_reg;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	logic mapped;
	logic acc;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_data;
	logic wr_addr;
	logic rd_data;
	logic [7:0] rd_val;

	assign mapped = hit(paddr, `I2CS_OFF_CTRL) | hit(paddr, `I2CS_OFF_STAT)
		| hit(paddr, `I2CS_OFF_DATA) | hit(paddr, `I2CS_OFF_ADDR);
	assign acc = psel & penable;
	assign wr_ctrl = acc & pwrite & hit(paddr, `I2CS_OFF_CTRL);
	assign wr_stat = acc & pwrite & hit(paddr, `I2CS_OFF_STAT);
	assign wr_data = acc & pwrite & hit(paddr, `I2CS_OFF_DATA);
	assign wr_addr = acc & pwrite & hit(paddr, `I2CS_OFF_ADDR);
	assign rd_data = acc & ~pwrite & hit(paddr, `I2CS_OFF_DATA);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign prdata = prdata_reg;

	always_comb begin
		if (hit(paddr, `I2CS_OFF_CTRL)) begin
			rd_val = {mode_reg, 3'h0, en_reg, 1'b0};
		end else if (hit(paddr, `I2CS_OFF_STAT)) begin
			rd_val = {cf_reg, match_reg, busy_reg, htx_reg, transmit_ack_control_reg, rw_reg, wake_en_reg, receive_ack_flag_reg};
		end else if (hit(paddr, `I2CS_OFF_DATA)) begin
			rd_val = data_reg;
		end else if (hit(paddr, `I2CS_OFF_ADDR)) begin
			rd_val = addr_reg;
		end else begin
			rd_val = 8'h00;
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop
	// and still allows a zero-wait access phase.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prdata_reg <= 32'h0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_reg <= {24'h0, rd_val};
		end
	end

	// ----------------------------------------------------------------
	// Bus event terms
	// ----------------------------------------------------------------
	logic active;
	logic en_rise;
	logic go;
	logic rise8;
	logic addr_hit;
	logic rx_rise8;
	logic tx_ack_rise;
	logic hold_rel;

	assign active = en_reg & (mode_reg == `I2CS_MODE_I2C);
	assign en_rise = en_reg & ~en_d_reg & (mode_reg == `I2CS_MODE_I2C);
	assign go = active & ~start_det & ~stop_det;
	assign rise8 = go & scl_rise & (cnt_reg == `I2CS_LAST_BIT);
	// bit 0 of the stored address is left out
	assign addr_hit = (shift_reg[6:0] == addr_reg[7:1]);
	assign rx_rise8 = rise8 & (state_reg == i2cs_pkg::ST_DATA) & ~htx_reg;
	assign tx_ack_rise = go & scl_rise & (state_reg == i2cs_pkg::ST_DACK) & htx_reg;
	// release on data write when sending, data read when receiving
	assign hold_rel = go & (state_reg == i2cs_pkg::ST_HOLD)
		& ((htx_reg & wr_data) | (~htx_reg & rd_data));

	// ----------------------------------------------------------------
	// Control and software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mode_reg <= `I2CS_MODE_RST;
			en_reg <= 1'b0;
			en_d_reg <= 1'b0;
			htx_reg <= 1'b0;
			transmit_ack_control_reg <= 1'b0;
			wake_en_reg <= 1'b0;
		end else begin
			en_d_reg <= en_reg;
			if (wr_ctrl) begin
				mode_reg <= pwdata[`I2CS_MODE_HI:`I2CS_MODE_LO];
				en_reg <= pwdata[`I2CS_EN_BIT];
			end
			if (wr_stat) begin
				htx_reg <= pwdata[`I2CS_HTX];
				transmit_ack_control_reg <= pwdata[`I2CS_TRANSMIT_ACK_CONTROL];
				wake_en_reg <= pwdata[`I2CS_WAKE];
			end
		end
	end

	// own address held by software; bit 0 stored as written
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			addr_reg <= 8'h00;
		end else if (wr_addr) begin
			addr_reg <= pwdata[7:0];
		end
	end

	// received byte wins over a software write in the same cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			data_reg <= 8'h00;
		end else if (rx_rise8) begin
			data_reg <= {shift_reg[6:0], sda_s};
		end else if (wr_data) begin
			data_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Status flags, set by the bus engine and defaulted on enable rising
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cf_reg <= 1'b1;
			match_reg <= 1'b0;
			busy_reg <= 1'b0;
			rw_reg <= 1'b0;
			receive_ack_flag_reg <= 1'b1;
		end else if (en_rise) begin
			// flags back to defaults, control bits kept
			cf_reg <= 1'b1;
			match_reg <= 1'b0;
			busy_reg <= 1'b0;
			rw_reg <= 1'b0;
			receive_ack_flag_reg <= 1'b1;
		end else if (active) begin
			if (start_det) begin
				busy_reg <= 1'b1;
				match_reg <= 1'b0;
				cf_reg <= 1'b0;
			end else if (stop_det) begin
				busy_reg <= 1'b0;
			end
			if (rise8 && state_reg == i2cs_pkg::ST_ADDR) begin
				match_reg <= addr_hit;
				rw_reg <= sda_s;
			end
			if (rx_rise8 | tx_ack_rise) begin
				cf_reg <= 1'b1;
			end else if (hold_rel) begin
				cf_reg <= 1'b0;
				match_reg <= 1'b0;
			end
			if (tx_ack_rise) begin
				receive_ack_flag_reg <= sda_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= i2cs_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
		end else if (!active || stop_det) begin
			state_reg <= i2cs_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
		end else if (start_det) begin
			state_reg <= i2cs_pkg::ST_ADDR;
			cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				i2cs_pkg::ST_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == `I2CS_BITS) begin
						state_reg <= match_reg ? i2cs_pkg::ST_AACK : i2cs_pkg::ST_WSTOP;
					end
				end
				i2cs_pkg::ST_AACK: begin
					if (scl_fall) begin
						state_reg <= i2cs_pkg::ST_HOLD;
					end
				end
				i2cs_pkg::ST_HOLD: begin
					if (hold_rel) begin
						state_reg <= i2cs_pkg::ST_DATA;
						cnt_reg <= 4'h0;
						if (htx_reg) begin
							shift_reg <= pwdata[7:0];
						end
					end
				end
				i2cs_pkg::ST_DATA: begin
					// eight bits, MSB first either way
					if (scl_rise) begin
						cnt_reg <= cnt_reg + 4'h1;
						if (!htx_reg) begin
							shift_reg <= {shift_reg[6:0], sda_s};
						end
					end else if (scl_fall && cnt_reg == `I2CS_BITS) begin
						state_reg <= i2cs_pkg::ST_DACK;
					end else if (scl_fall && htx_reg) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
				i2cs_pkg::ST_DACK: begin
					if (scl_fall) begin
						// no acknowledge: let go and wait for stop
						state_reg <= (htx_reg && receive_ack_flag_reg) ? i2cs_pkg::ST_WSTOP
							: i2cs_pkg::ST_HOLD;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drive and event outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sda_oe_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			// address ack; ack bit; transmit data bit
			sda_oe_reg <= active & ((state_reg == i2cs_pkg::ST_AACK)
				| (state_reg == i2cs_pkg::ST_DACK & ~htx_reg & ~transmit_ack_control_reg)
				| (state_reg == i2cs_pkg::ST_DATA & htx_reg & ~shift_reg[7]));
			// clock stretched while waiting for software
			scl_oe_reg <= active & (state_reg == i2cs_pkg::ST_HOLD) & ~hold_rel;
			// request on match; request on byte done
			irq_reg <= (rise8 & (state_reg == i2cs_pkg::ST_ADDR) & addr_hit)
				| rx_rise8 | tx_ack_rise;
			wake_reg <= rise8 & (state_reg == i2cs_pkg::ST_ADDR) & addr_hit & wake_en_reg;
		end
	end

	assign sda_oe = sda_oe_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_o = 1'b0;
	assign scl_o = 1'b0;
	assign irq_req = irq_reg;
	assign wake_req = wake_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_busy_start: assert property (active & start_det |=> busy_reg)
		else $error("busy flag not set by start");
	chk_busy_stop: assert property (active & stop_det & ~en_rise |=> !busy_reg)
		else $error("busy flag not cleared by stop");
	chk_match_irq: assert property (rise8 & state_reg == i2cs_pkg::ST_ADDR & addr_hit
		|=> match_reg & irq_req) else $error("match did not flag and request");
	chk_rw_capture: assert property (rise8 & state_reg == i2cs_pkg::ST_ADDR
		|=> rw_reg == $past(sda_s)) else $error("read/write bit not captured");
	chk_addr_ack: assert property (active & state_reg == i2cs_pkg::ST_AACK
		|=> sda_oe) else $error("address acknowledge not driven");
	chk_scl_hold: assert property (go & state_reg == i2cs_pkg::ST_HOLD & ~hold_rel
		|=> scl_oe ##0 state_reg == i2cs_pkg::ST_HOLD) else $error("clock not held");
	chk_transmit_ack_control_drive: assert property (active & state_reg == i2cs_pkg::ST_DACK & ~htx_reg
		|=> sda_oe == !$past(transmit_ack_control_reg)) else $error("ack bit not driven");
	chk_nack_release: assert property (go & scl_fall & state_reg == i2cs_pkg::ST_DACK
		& htx_reg & receive_ack_flag_reg |=> state_reg == i2cs_pkg::ST_WSTOP ##1 !sda_oe)
		else $error("no release after missing ack");
	chk_rx_store: assert property (rx_rise8 & ~en_rise
		|=> data_reg == $past({shift_reg[6:0], sda_s}) & cf_reg) else $error("byte not stored");
	chk_flag_default: assert property (en_rise
		|=> cf_reg & !busy_reg & !match_reg & receive_ack_flag_reg) else $error("flags not defaulted");

	cov_match: cover property (rise8 & state_reg == i2cs_pkg::ST_ADDR & addr_hit);
	cov_rx_byte: cover property (rx_rise8);
	cov_tx_nack: cover property (tx_ack_rise & sda_s);
endmodule

// >>> tb/i2cs_bus_master.sv
`timescale 1ns/100ps
module i2cs_bus_master (
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl_line,
	output logic sda_line
);
	logic m_scl_oe = 1'h0;
	logic m_sda_oe = 1'h0;
	// ----
	// Wire levels
	// ----
	// Both lines have pull-ups, so a line nobody pulls reads high.
	assign scl_line = ~(m_scl_oe | scl_oe);
	assign sda_line = ~(m_sda_oe | sda_oe);
	// ----
	// Bus actions
	// ----
	// master makes start
	task automatic start();
		#100 m_sda_oe = 1'h1;
		#100 m_scl_oe = 1'h1;
	endtask
	task automatic stop();
		#50 m_sda_oe = 1'h1;
		#50 m_scl_oe = 1'h0;
		while (scl_line !== 1'h1) #25;
		#100 m_sda_oe = 1'h0;
		#100;
	endtask
	// The slave may stretch the low phase, so the wire itself is awaited.
	task automatic bit_io(input logic b, output logic s);
		#50 m_sda_oe = ~b;
		#50 m_scl_oe = 1'h0;
		while (scl_line !== 1'h1) #25;
		#90 s = sda_line;
		#10 m_scl_oe = 1'h1;
	endtask
	// Lets go of the clock for a while and reports the wire, then pulls it low again.
	// The slave's own hold is the only thing that can keep the wire low meanwhile.
	task automatic probe_scl(output logic s);
		#50 m_scl_oe = 1'h0;
		#100 s = scl_line;
		m_scl_oe = 1'h1;
		#50;
	endtask
	task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
			output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack_out);
	endtask
endmodule

// >>> tb/test_i2c_slave_serial_port.sv
`timescale 1ns/100ps
`include "i2cs_consts.svh"
module test_i2c_slave_serial_port;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, scl_oe, sda_oe, irq_req, wake_req, scl_line, sda_line;
	logic [7:0] q, rx;
	logic ack, last_err;
	int miscompares = 0;
	int comparisons = 0;
	int irqs = 0;
	int wakes = 0;
	int cycles = 0;
	always #12.5 core_clk = ~core_clk;
	i2cs_top dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .irq_req(irq_req),
		.wake_req(wake_req));
	i2cs_bus_master m (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line),
		.sda_line(sda_line));
	// ----
	// Helpers
	// ----
	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] r);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1) @(posedge core_clk);
		r = prdata[7:0];
		last_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask,
			input logic [7:0] e, input string what);
		logic [7:0] r;
		apb(1'h0, a, 8'h00, r);
		chk(what, e, r & mask);
	endtask
	// pulse counter stands in
	// Counts event pulses and cuts a hang short.
	always @(posedge core_clk) begin
		cycles++;
		if (irq_req === 1'h1) irqs++;
		if (wake_req === 1'h1) wakes++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'h1;
		rd_chk(`I2CS_OFF_CTRL, 8'hFF, 8'hE0, "ctrl");
		rd_chk(`I2CS_OFF_STAT, 8'hFF, 8'h81, "stat");
		rd_chk(8'h10, 8'hFF, 8'h00, "unmapped");
		chk("slverr", 8'h01, {7'h00, last_err});
		$display("test reset done");
		apb(1'h1, `I2CS_OFF_CTRL, 8'hC2, q);
		apb(1'h1, `I2CS_OFF_ADDR, 8'hA5, q);
		rd_chk(`I2CS_OFF_ADDR, 8'hFF, 8'hA5, "addr");
		apb(1'h1, `I2CS_OFF_STAT, 8'h02, q);
		rd_chk(`I2CS_OFF_STAT, 8'hFF, 8'h83, "stat en");
		m.start();
		rd_chk(`I2CS_OFF_STAT, 8'h20, 8'h20, "busy");
		m.xfer_byte({7'h52, 1'h0}, 1'h1, rx, ack);
		chk("addr ack", 8'h00, {7'h00, ack});
		rd_chk(`I2CS_OFF_STAT, 8'h64, 8'h60, "match");
		chk("irqs", 8'h01, 8'(irqs));
		chk("wakes", 8'h01, 8'(wakes));
		repeat (10) @(posedge core_clk);
		m.probe_scl(ack);
		chk("scl held", 8'h00, {7'h00, ack});
		apb(1'h0, `I2CS_OFF_DATA, 8'h00, q);
		m.xfer_byte(8'h3C, 1'h1, rx, ack);
		chk("data ack", 8'h00, {7'h00, ack});
		rd_chk(`I2CS_OFF_STAT, 8'hC0, 8'h80, "done");
		chk("irqs", 8'h02, 8'(irqs));
		rd_chk(`I2CS_OFF_DATA, 8'hFF, 8'h3C, "rx byte");
		apb(1'h1, `I2CS_OFF_STAT, 8'h0A, q);
		m.xfer_byte(8'hC1, 1'h1, rx, ack);
		chk("data nak", 8'h01, {7'h00, ack});
		rd_chk(`I2CS_OFF_DATA, 8'hFF, 8'hC1, "rx byte");
		m.stop();
		rd_chk(`I2CS_OFF_STAT, 8'h20, 8'h00, "free");
		$display("test slave receive done");
		apb(1'h1, `I2CS_OFF_STAT, 8'h00, q);
		m.start();
		m.xfer_byte({7'h52, 1'h1}, 1'h1, rx, ack);
		rd_chk(`I2CS_OFF_STAT, 8'h44, 8'h44, "rw");
		chk("wakes", 8'h01, 8'(wakes));
		apb(1'h1, `I2CS_OFF_STAT, 8'h10, q);
		apb(1'h1, `I2CS_OFF_DATA, 8'h96, q);
		m.xfer_byte(8'hFF, 1'h0, rx, ack);
		chk("tx byte", 8'h96, rx);
		rd_chk(`I2CS_OFF_STAT, 8'h81, 8'h80, "ack in");
		apb(1'h1, `I2CS_OFF_DATA, 8'h5A, q);
		m.xfer_byte(8'hFF, 1'h1, rx, ack);
		chk("tx byte", 8'h5A, rx);
		rd_chk(`I2CS_OFF_STAT, 8'h81, 8'h81, "nak in");
		repeat (10) @(posedge core_clk);
		chk("sda free", 8'h01, {7'h00, sda_line});
		m.stop();
		chk("irqs", 8'h06, 8'(irqs));
		$display("test slave transmit done");
		m.start();
		m.xfer_byte({7'h53, 1'h0}, 1'h1, rx, ack);
		chk("no match", 8'h01, {7'h00, ack});
		m.stop();
		chk("irqs", 8'h06, 8'(irqs));
		apb(1'h1, `I2CS_OFF_STAT, 8'h18, q);
		apb(1'h1, `I2CS_OFF_CTRL, 8'hC0, q);
		apb(1'h1, `I2CS_OFF_CTRL, 8'hC2, q);
		rd_chk(`I2CS_OFF_STAT, 8'hFF, 8'h99, "re-enable");
		$display("test other address done");
		finish_test();
	end
endmodule
